// ### design/pmd_decoder.sv
`timescale 1ns/1ns
// Summary of operation
// - add: register 1 byte 1 cycle; direct, immediate 2/2; indirect 1 byte 2 cycles
// - add with carry: same forms and timing as plain add
// - subtract with borrow: register 1 cycle; direct, indirect, immediate 2 cycles
// - and into accumulator: register 1 cycle; other forms 2 cycles
// - and into direct byte: 2 or 3 bytes, 3 cycles, read-modify-write
// - or into accumulator: register 1 cycle; other forms 2 cycles
// - or into direct byte: 2 or 3 bytes, 3 cycles
// - exclusive or into accumulator: register 1 cycle; other forms 2 cycles
// - exclusive or into direct byte: 2 or 3 bytes, 3 cycles
// - four accumulator rotates, 1 byte 1 cycle; through-carry forms use carry
// - nibble swap of accumulator: 1 byte, 4 cycles
// - moves into accumulator: register 1 cycle; direct, indirect, immediate 2 cycles
// - moves into working register with their own lengths and cycle counts
// - moves into direct byte with their own lengths and cycle counts
// - moves into indirect RAM with their own lengths and cycle counts
// - data pointer load: 3 bytes, 16-bit immediate, 3 cycles
// - code table reads: data pointer based 7 cycles, counter based 8 cycles
// - external RAM reads: 8-bit address 5 cycles, 16-bit address 6 cycles
// - external RAM writes: 8-bit address 4 cycles, 16-bit address 5 cycles
// - push 2 bytes 5 cycles; pop 2 bytes 4 cycles
// - exchange with register 3 cycles; with direct or indirect 4 cycles
// - low nibble exchange with indirect RAM: 1 byte, 4 cycles
module pmd_decoder
   import pmd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  code_data,     // byte at code_addr
   input  wire logic        code_valid,    // code_data valid, byte taken this cycle
   input  wire logic        muldiv_wide,   // multiply/divide use the 16-by-8 form
   output logic             code_req,
   output logic [15:0]      code_addr,
   output logic             ret_valid,
   output pmd_dec_t         ret_dec,
   output logic [7:0]       ret_opcode,
   output logic [15:0]      ret_operand,
   output logic [2:0]       ret_reg_sel,
   output logic             ret_ptr_sel
);

   // ****************************************************************
   // decode helpers
   // ****************************************************************
   // build one table entry; carry follows from the class, read-modify-write from class and destination
   function automatic pmd_dec_t pmd_mk(input pmd_cls_t cls, input pmd_opnd_t src,
                                       input pmd_opnd_t dst, input logic [LEN_W-1:0] len,
                                       input logic [CYC_W-1:0] cyc);
      pmd_dec_t d;
      d.known  = 1'b1;
      d.cls    = cls;
      d.src    = src;
      d.dst    = dst;
      d.len    = len;
      d.cycles = cyc;
      d.carry  = cls inside {CLS_ADD_WITH_CARRY, CLS_SUBTRACT_WITH_BORROW,
                             CLS_ROT_LC, CLS_ROT_RC};
      d.rmw    = cls inside {CLS_AND, CLS_OR, CLS_XOR, CLS_INC, CLS_DEC} &&
                 dst inside {OPND_DIRECT, OPND_INDIRECT_REGISTER_POINTER};
      return d;
   endfunction : pmd_mk

   function automatic pmd_dec_t pmd_decode(input logic [7:0] op, input logic wide);
      pmd_dec_t         d;
      pmd_cls_t         acls;
      logic             alu;
      logic             logic_op;
      logic [NIB_W-1:0] lo;
      lo       = op[NIB_W-1:0];
      d        = pmd_mk(CLS_OTHER, OPND_NONE, OPND_NONE, LEN_ONE, CYC_ALU_REG);
      d.known  = 1'b0;
      alu      = 1'b1;
      logic_op = 1'b0;
      // column of accumulator arithmetic and logic forms
      case (op[7:4])
         4'h2:    acls = CLS_ADD;
         4'h3:    acls = CLS_ADD_WITH_CARRY;
         4'h9:    acls = CLS_SUBTRACT_WITH_BORROW;
         4'h5:    begin acls = CLS_AND; logic_op = 1'b1; end
         4'h4:    begin acls = CLS_OR;  logic_op = 1'b1; end
         4'h6:    begin acls = CLS_XOR; logic_op = 1'b1; end
         default: begin acls = CLS_OTHER; alu = 1'b0; end
      endcase
      if (alu) begin
         if (lo >= LO_REG)
            d = pmd_mk(acls, OPND_WORKING_REGISTER, OPND_ACC, LEN_ONE, CYC_ALU_REG);
         else if (lo == 4'h4)
            d = pmd_mk(acls, OPND_IMM, OPND_ACC, LEN_TWO, CYC_ALU_MEM);
         else if (lo == 4'h5)
            d = pmd_mk(acls, OPND_DIRECT, OPND_ACC, LEN_TWO, CYC_ALU_MEM);
         else if (lo inside {4'h6, 4'h7})
            d = pmd_mk(acls, OPND_INDIRECT_REGISTER_POINTER, OPND_ACC, LEN_ONE, CYC_ALU_MEM);
         else if (logic_op && lo == 4'h2)
            d = pmd_mk(acls, OPND_ACC, OPND_DIRECT, LEN_TWO, CYC_RMW);
         else if (logic_op && lo == 4'h3)
            d = pmd_mk(acls, OPND_IMM, OPND_DIRECT, LEN_THREE, CYC_RMW);
      end
      // increment and decrement columns
      if (op[7:5] == 3'h0) begin
         acls = op[4] ? CLS_DEC : CLS_INC;
         if (lo >= LO_REG)
            d = pmd_mk(acls, OPND_NONE, OPND_WORKING_REGISTER, LEN_ONE, CYC_INC_REG);
         else if (lo == 4'h4)
            d = pmd_mk(acls, OPND_NONE, OPND_ACC, LEN_ONE, CYC_ALU_REG);
         else if (lo == 4'h5)
            d = pmd_mk(acls, OPND_NONE, OPND_DIRECT, LEN_TWO, CYC_INC_MEM);
         else if (lo inside {4'h6, 4'h7})
            d = pmd_mk(acls, OPND_NONE, OPND_INDIRECT_REGISTER_POINTER, LEN_ONE, CYC_INC_MEM);
      end
      // ranges of moves and exchanges
      if (op inside {[8'hE8:8'hEF]})
         d = pmd_mk(CLS_MOVE, OPND_WORKING_REGISTER, OPND_ACC, LEN_ONE, CYC_ALU_REG);
      else if (op inside {[8'hF8:8'hFF]})
         d = pmd_mk(CLS_MOVE, OPND_ACC, OPND_WORKING_REGISTER, LEN_ONE, CYC_MOV_FAST);
      else if (op inside {[8'hA8:8'hAF]})
         d = pmd_mk(CLS_MOVE, OPND_DIRECT, OPND_WORKING_REGISTER, LEN_TWO, CYC_MOV_SLOW);
      else if (op inside {[8'h78:8'h7F]})
         d = pmd_mk(CLS_MOVE, OPND_IMM, OPND_WORKING_REGISTER, LEN_TWO, CYC_MOV_FAST);
      else if (op inside {[8'h88:8'h8F]})
         d = pmd_mk(CLS_MOVE, OPND_WORKING_REGISTER, OPND_DIRECT, LEN_TWO, CYC_MOV_FAST);
      else if (op inside {[8'hC8:8'hCF]})
         d = pmd_mk(CLS_EXCHANGE, OPND_WORKING_REGISTER, OPND_ACC, LEN_ONE, CYC_XCH_REG);
      // single opcodes and pointer pairs
      case (op)
         8'hA3: d = pmd_mk(CLS_INC_DP, OPND_NONE, OPND_DATA_POINTER, LEN_ONE, CYC_INC_DP);
         8'hA4: d = pmd_mk(CLS_MUL, OPND_ACC, OPND_ACC, LEN_ONE,
                           wide ? CYC_MULDIV16 : CYC_MULDIV8);
         8'h84: d = pmd_mk(CLS_DIV, OPND_ACC, OPND_ACC, LEN_ONE,
                           wide ? CYC_MULDIV16 : CYC_MULDIV8);
         8'hD4: d = pmd_mk(CLS_DEC_ADJ, OPND_ACC, OPND_ACC, LEN_ONE, CYC_ALU_REG);
         8'hE4: d = pmd_mk(CLS_CLEAR, OPND_NONE, OPND_ACC, LEN_ONE, CYC_ALU_REG);
         8'hF4: d = pmd_mk(CLS_COMPL, OPND_ACC, OPND_ACC, LEN_ONE, CYC_ALU_REG);
         8'h23: d = pmd_mk(CLS_ROT_L, OPND_ACC, OPND_ACC, LEN_ONE, CYC_ALU_REG);
         8'h33: d = pmd_mk(CLS_ROT_LC, OPND_ACC, OPND_ACC, LEN_ONE, CYC_ALU_REG);
         8'h03: d = pmd_mk(CLS_ROT_R, OPND_ACC, OPND_ACC, LEN_ONE, CYC_ALU_REG);
         8'h13: d = pmd_mk(CLS_ROT_RC, OPND_ACC, OPND_ACC, LEN_ONE, CYC_ALU_REG);
         8'hC4: d = pmd_mk(CLS_SWAP, OPND_ACC, OPND_ACC, LEN_ONE, CYC_SWAP);
         8'hE5: d = pmd_mk(CLS_MOVE, OPND_DIRECT, OPND_ACC, LEN_TWO, CYC_ALU_MEM);
         8'hE6, 8'hE7:
                d = pmd_mk(CLS_MOVE, OPND_INDIRECT_REGISTER_POINTER, OPND_ACC, LEN_ONE,
                           CYC_ALU_MEM);
         8'h74: d = pmd_mk(CLS_MOVE, OPND_IMM, OPND_ACC, LEN_TWO, CYC_ALU_MEM);
         8'hF5: d = pmd_mk(CLS_MOVE, OPND_ACC, OPND_DIRECT, LEN_TWO, CYC_MOV_FAST);
         8'h86, 8'h87:
                d = pmd_mk(CLS_MOVE, OPND_INDIRECT_REGISTER_POINTER, OPND_DIRECT, LEN_TWO,
                           CYC_MOV_SLOW);
         8'h75: d = pmd_mk(CLS_MOVE, OPND_IMM, OPND_DIRECT, LEN_THREE, CYC_MOV_SLOW);
         8'h85: d = pmd_mk(CLS_MOVE, OPND_DIRECT, OPND_DIRECT, LEN_THREE, CYC_MOV_SLOW);
         8'hF6, 8'hF7:
                d = pmd_mk(CLS_MOVE, OPND_ACC, OPND_INDIRECT_REGISTER_POINTER, LEN_ONE,
                           CYC_MOV_FAST);
         8'hA6, 8'hA7:
                d = pmd_mk(CLS_MOVE, OPND_DIRECT, OPND_INDIRECT_REGISTER_POINTER, LEN_TWO,
                           CYC_MOV_SLOW);
         8'h76, 8'h77:
                d = pmd_mk(CLS_MOVE, OPND_IMM, OPND_INDIRECT_REGISTER_POINTER, LEN_TWO,
                           CYC_MOV_FAST);
         8'h90: d = pmd_mk(CLS_LOAD_DP, OPND_IMM, OPND_DATA_POINTER, LEN_THREE,
                           CYC_LOAD_DP);
         8'h93: d = pmd_mk(CLS_CODE_TABLE_READ, OPND_CODE, OPND_ACC, LEN_ONE,
                           CYC_CODE_DP);
         8'h83: d = pmd_mk(CLS_CODE_TABLE_READ, OPND_CODE, OPND_ACC, LEN_ONE,
                           CYC_CODE_PC);
         8'hE2, 8'hE3:
                d = pmd_mk(CLS_EXTERNAL_RAM_MOVE, OPND_XRAM, OPND_ACC, LEN_ONE,
                           CYC_XRD_IND);
         8'hE0: d = pmd_mk(CLS_EXTERNAL_RAM_MOVE, OPND_XRAM, OPND_ACC, LEN_ONE, CYC_XRD_DP);
         8'hF2, 8'hF3:
                d = pmd_mk(CLS_EXTERNAL_RAM_MOVE, OPND_ACC, OPND_XRAM, LEN_ONE,
                           CYC_XWR_IND);
         8'hF0: d = pmd_mk(CLS_EXTERNAL_RAM_MOVE, OPND_ACC, OPND_XRAM, LEN_ONE, CYC_XWR_DP);
         8'hC0: d = pmd_mk(CLS_PUSH, OPND_DIRECT, OPND_STACK, LEN_TWO, CYC_PUSH);
         8'hD0: d = pmd_mk(CLS_POP, OPND_STACK, OPND_DIRECT, LEN_TWO, CYC_POP);
         8'hC5: d = pmd_mk(CLS_EXCHANGE, OPND_DIRECT, OPND_ACC, LEN_TWO, CYC_XCH_MEM);
         8'hC6, 8'hC7:
                d = pmd_mk(CLS_EXCHANGE, OPND_INDIRECT_REGISTER_POINTER, OPND_ACC, LEN_ONE,
                           CYC_XCH_MEM);
         8'hD6, 8'hD7:
                d = pmd_mk(CLS_LOW_NIBBLE_EXCHANGE, OPND_INDIRECT_REGISTER_POINTER,
                           OPND_ACC, LEN_ONE, CYC_XCH_MEM);
         default: ;
      endcase
      return d;
   endfunction : pmd_decode

   // ****************************************************************
   // sequencer
   // ****************************************************************
   pmd_state_t       s_reg;
   pmd_state_t       s_next;
   pmd_dec_t         cur;
   logic             need;
   logic             adv;
   logic [CYC_W-1:0] cnt_plus;

   // one machine cycle passes per clock unless a requested opcode or operand byte is awaited
   always_comb begin
      s_next           = s_reg;
      s_next.ret_valid = 1'b0;
      cur      = (s_reg.st == ST_FETCH) ? pmd_decode(code_data, muldiv_wide) : s_reg.dec;
      need     = (s_reg.st == ST_EXEC) && (s_reg.fetched < s_reg.dec.len);
      code_req = (s_reg.st == ST_FETCH) || need;
      adv      = code_req ? code_valid : 1'b1;
      cnt_plus = (s_reg.st == ST_FETCH) ? CYC_ALU_REG : CYC_W'(s_reg.cnt + 5'h01);
      if (code_req && code_valid) begin
         s_next.pc      = 16'(s_reg.pc + 16'h0001);
         s_next.fetched = LEN_W'(s_reg.fetched + 2'h1);
         if (s_reg.st == ST_FETCH) begin
            s_next.opcode  = code_data;
            s_next.dec     = cur;
            s_next.op1     = 8'h00;
            s_next.op2     = 8'h00;
            s_next.fetched = LEN_ONE;
         end else if (s_reg.fetched == LEN_ONE) begin
            s_next.op1 = code_data;
         end else begin
            s_next.op2 = code_data;
         end
      end
      if (adv) begin
         s_next.cnt = cnt_plus;
         s_next.st  = ST_EXEC;
         // retire on the last machine cycle, whole instruction reported at once
         if (cnt_plus == cur.cycles) begin
            s_next.st          = ST_FETCH;
            s_next.cnt         = '0;
            s_next.ret_valid   = 1'b1;
            s_next.ret_dec     = cur;
            s_next.ret_opcode  = s_next.opcode;
            s_next.ret_operand = {s_next.op1, s_next.op2};
         end
      end
   end

   // synchronous reset, program counter restarts at the reset vector
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_reg    <= '0;
         s_reg.pc <= PC_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign code_addr   = s_reg.pc;
   assign ret_valid   = s_reg.ret_valid;
   assign ret_dec     = s_reg.ret_dec;
   assign ret_opcode  = s_reg.ret_opcode;
   assign ret_operand = s_reg.ret_operand;
   assign ret_reg_sel = s_reg.ret_opcode[REG_SEL_W-1:0];
   assign ret_ptr_sel = s_reg.ret_opcode[0];

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic [CYC_W-1:0] mc_seen_reg;  // machine cycles seen, counted apart from the sequencer
   always_ff @(posedge clk) begin
      if (!rst_n)
         mc_seen_reg <= '0;
      else if (adv)
         mc_seen_reg <= (s_reg.st == ST_FETCH) ? 5'h01 : CYC_W'(mc_seen_reg + 5'h01);
   end

   sequence s_start(logic [7:0] o);
      s_reg.st == ST_FETCH && code_valid && code_data == o;
   endsequence

   chk_add_reg_one: assert property (s_start(8'h28) |=>
      ret_valid && ret_dec.len == LEN_ONE)
      else $error("register add did not retire after one cycle");
   chk_add_with_carry_ind_two: assert property (s_start(8'h36) |=> !ret_valid ##1 ret_valid)
      else $error("indirect add with carry not two cycles");
   chk_subtract_with_borrow_imm_form: assert property (ret_valid && ret_opcode == 8'h94 |->
      ret_dec.len == LEN_TWO && ret_dec.cycles == CYC_ALU_MEM)
      else $error("immediate subtract form wrong");
   chk_and_dir_rmw: assert property (ret_valid && ret_opcode == 8'h53 |->
      ret_dec.len == LEN_THREE && ret_dec.cycles == CYC_RMW && ret_dec.rmw)
      else $error("and into direct byte wrong");
   chk_rotate_carry: assert property (ret_valid && ret_opcode inside {8'h33, 8'h13} |->
      ret_dec.carry && ret_dec.cycles == CYC_ALU_REG)
      else $error("rotate through carry wrong");
   chk_swap_four: assert property (s_start(8'hC4) |=> !ret_valid [*3] ##1 ret_valid)
      else $error("nibble swap not four cycles");
   chk_code_pc_eight: assert property (s_start(8'h83) |->
      ##8 ret_valid && ret_opcode == 8'h83)
      else $error("counter based table read not eight cycles");
   chk_xram_dp_read: assert property (s_start(8'hE0) |-> ##6 ret_valid)
      else $error("external read by data pointer not six cycles");
   chk_muldiv_wide: assert property (s_start(8'hA4) ##0 muldiv_wide |-> ##20 ret_valid)
      else $error("wide multiply not twenty cycles");
   chk_mcycle_count: assert property (ret_valid |-> mc_seen_reg == ret_dec.cycles)
      else $error("retired cycle count differs from machine cycles seen");

endmodule : pmd_decoder

// ### include/pmd_pkg.sv
package pmd_pkg;

   // ****************************************************************
   // widths and field positions
   // ****************************************************************
   localparam int         CYC_W      = 5;
   localparam int         LEN_W      = 2;
   localparam int         REG_SEL_W  = 3;
   localparam int         NIB_W      = 4;
   localparam logic [15:0] PC_RESET  = 16'h0000;
   localparam logic [3:0]  LO_REG    = 4'h8;   // low nibbles 8..F select a working register

   // ****************************************************************
   // instruction lengths in bytes
   // ****************************************************************
   localparam logic [LEN_W-1:0] LEN_ONE   = 2'h1;
   localparam logic [LEN_W-1:0] LEN_TWO   = 2'h2;
   localparam logic [LEN_W-1:0] LEN_THREE = 2'h3;

   // ****************************************************************
   // execution times in machine cycles (one machine cycle = one clock)
   // ****************************************************************
   localparam logic [CYC_W-1:0] CYC_ALU_REG  = 5'h01;
   localparam logic [CYC_W-1:0] CYC_ALU_MEM  = 5'h02;
   localparam logic [CYC_W-1:0] CYC_RMW      = 5'h03;
   localparam logic [CYC_W-1:0] CYC_INC_REG  = 5'h02;
   localparam logic [CYC_W-1:0] CYC_INC_MEM  = 5'h03;
   localparam logic [CYC_W-1:0] CYC_INC_DP   = 5'h04;
   localparam logic [CYC_W-1:0] CYC_MULDIV8  = 5'h0B;
   localparam logic [CYC_W-1:0] CYC_MULDIV16 = 5'h14;
   localparam logic [CYC_W-1:0] CYC_SWAP     = 5'h04;
   localparam logic [CYC_W-1:0] CYC_MOV_FAST = 5'h02;
   localparam logic [CYC_W-1:0] CYC_MOV_SLOW = 5'h03;
   localparam logic [CYC_W-1:0] CYC_LOAD_DP  = 5'h03;
   localparam logic [CYC_W-1:0] CYC_CODE_DP  = 5'h07;
   localparam logic [CYC_W-1:0] CYC_CODE_PC  = 5'h08;
   localparam logic [CYC_W-1:0] CYC_XRD_IND  = 5'h05;
   localparam logic [CYC_W-1:0] CYC_XRD_DP   = 5'h06;
   localparam logic [CYC_W-1:0] CYC_XWR_IND  = 5'h04;
   localparam logic [CYC_W-1:0] CYC_XWR_DP   = 5'h05;
   localparam logic [CYC_W-1:0] CYC_PUSH     = 5'h05;
   localparam logic [CYC_W-1:0] CYC_POP      = 5'h04;
   localparam logic [CYC_W-1:0] CYC_XCH_REG  = 5'h03;
   localparam logic [CYC_W-1:0] CYC_XCH_MEM  = 5'h04;

   // ****************************************************************
   // operation classes, operand kinds, states
   // ****************************************************************
   typedef enum logic [4:0] {
      CLS_OTHER, CLS_ADD, CLS_ADD_WITH_CARRY, CLS_SUBTRACT_WITH_BORROW,
      CLS_INC, CLS_DEC, CLS_INC_DP, CLS_MUL, CLS_DIV, CLS_DEC_ADJ,
      CLS_AND, CLS_OR, CLS_XOR, CLS_CLEAR, CLS_COMPL,
      CLS_ROT_L, CLS_ROT_LC, CLS_ROT_R, CLS_ROT_RC, CLS_SWAP,
      CLS_MOVE, CLS_LOAD_DP, CLS_CODE_TABLE_READ, CLS_EXTERNAL_RAM_MOVE,
      CLS_PUSH, CLS_POP, CLS_EXCHANGE, CLS_LOW_NIBBLE_EXCHANGE
   } pmd_cls_t;

   typedef enum logic [3:0] {
      OPND_NONE, OPND_ACC, OPND_WORKING_REGISTER, OPND_DIRECT,
      OPND_INDIRECT_REGISTER_POINTER, OPND_IMM, OPND_DATA_POINTER,
      OPND_CODE, OPND_XRAM, OPND_STACK
   } pmd_opnd_t;

   typedef enum logic {ST_FETCH = 1'b0, ST_EXEC = 1'b1} pmd_st_t;

   typedef struct packed {
      logic             known;
      pmd_cls_t         cls;
      pmd_opnd_t        src;
      pmd_opnd_t        dst;
      logic [LEN_W-1:0] len;
      logic [CYC_W-1:0] cycles;
      logic             carry;   // carry flag takes part in the operation
      logic             rmw;     // destination byte is read, modified, written
   } pmd_dec_t;

   typedef struct packed {
      pmd_st_t          st;
      logic [15:0]      pc;
      pmd_dec_t         dec;
      logic [7:0]       opcode;
      logic [7:0]       op1;
      logic [7:0]       op2;
      logic [LEN_W-1:0] fetched;
      logic [CYC_W-1:0] cnt;
      logic             ret_valid;
      pmd_dec_t         ret_dec;
      logic [7:0]       ret_opcode;
      logic [15:0]      ret_operand;
   } pmd_state_t;

endpackage : pmd_pkg

// ### dv/pmd_code_mem.sv
`timescale 1ns/1ns
module pmd_code_mem (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        code_req,
   input  wire logic [15:0] code_addr,
   input  wire logic [15:0] stall_addr,
   output logic             code_valid,
   output logic [7:0]       code_data
);
   logic [7:0] mem [0:255];
   logic       held_reg;
   // one refused cycle the first time the stall address is asked for
   always_ff @(posedge clk) begin
      held_reg <= rst_n && (code_addr == stall_addr);
   end
   assign code_valid = code_req && (held_reg || (code_addr != stall_addr));
   // outside a valid cycle the bus shows the inverse, so a stale byte cannot pass
   assign code_data  = code_valid ? mem[code_addr[7:0]] : ~mem[code_addr[7:0]];
endmodule : pmd_code_mem

// ### dv/pmd_decoder_tb.sv
`timescale 1ns/1ns
module pmd_decoder_tb
   import pmd_pkg::*;
;
   typedef struct {logic [7:0] op; int ln; int cy; int gp;} pmd_ent_t;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        muldiv_wide = 1'b0;
   logic [15:0] stall_addr = 16'hFFFF;
   logic        code_req, code_valid, ret_valid, ret_ptr_sel;
   logic [7:0]  code_data, ret_opcode;
   logic [15:0] code_addr, ret_operand;
   logic [2:0]  ret_reg_sel;
   pmd_dec_t    ret_dec;
   pmd_ent_t    ent [$];
   int          n_mismatch = 0;
   int          tests_run = 0;
   always #2 clk = ~clk;
   pmd_decoder DUT (.clk(clk), .rst_n(rst_n), .code_data(code_data), .code_valid(code_valid),
      .muldiv_wide(muldiv_wide), .code_req(code_req), .code_addr(code_addr),
      .ret_valid(ret_valid), .ret_dec(ret_dec), .ret_opcode(ret_opcode),
      .ret_operand(ret_operand), .ret_reg_sel(ret_reg_sel), .ret_ptr_sel(ret_ptr_sel));
   pmd_code_mem MEM (.clk(clk), .rst_n(rst_n), .code_req(code_req), .code_addr(code_addr),
      .stall_addr(stall_addr), .code_valid(code_valid), .code_data(code_data));
   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic add(input logic [7:0] op, input int ln, input int cy, input int gp = 0);
      ent.push_back('{op, ln, cy, cy + gp});
   endtask : add
   // loads the program, resets, then judges every retire; the first entry is a
   // one-cycle filler so that each later gap is measured from a retire
   task automatic run();
      int          a;
      int          n;
      logic [15:0] xo;
      a = 0;
      foreach (ent[k]) begin
         MEM.mem[a] = ent[k].op;
         MEM.mem[a+1] = {4'hA, 4'(k)};
         MEM.mem[a+2] = {4'h5, 4'(k)};
         a = a + ent[k].ln;
      end
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      foreach (ent[k]) begin
         n = 0;
         do begin
            @(posedge clk);
            #1 n++;
         end while (ret_valid !== 1'b1 && n < 40);
         xo = (ent[k].ln == 1) ? 16'h0000 : {4'hA, 4'(k), 8'h00};
         xo[7:0] = (ent[k].ln == 3) ? {4'h5, 4'(k)} : 8'h00;
         if (k > 0) chk(16'(n), 16'(ent[k].gp), "gap");
         chk(16'(ret_opcode), 16'(ent[k].op), "opcode");
         chk(16'(ret_dec.len), 16'(ent[k].ln), "length");
         chk(16'(ret_dec.cycles), 16'(ent[k].cy), "cycles");
         chk(ret_operand, xo, "operand");
         chk(16'(ret_dec.known), 16'(ent[k].op != 8'h00), "known");
         chk(16'({ret_reg_sel, ret_ptr_sel}),
            16'({ent[k].op[2:0], ent[k].op[0]}), "sel");
         chk(16'(ret_dec.carry), 16'(ent[k].op inside
            {[8'h34:8'h3F], [8'h94:8'h9F], 8'h13, 8'h33}), "carry");
         chk(16'(ret_dec.rmw), 16'(ent[k].op inside {8'h42, 8'h43, 8'h52,
            8'h53, 8'h62, 8'h63, [8'h05:8'h07], [8'h15:8'h17]}), "rmw");
      end
   endtask : run
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_arith();
      ent.delete();
      muldiv_wide = 1'b0;
      add(8'h00, 1, 1);
      add(8'h2F, 1, 1);
      add(8'h24, 2, 2);
      add(8'h34, 2, 2);
      add(8'h36, 1, 2);
      add(8'h25, 2, 2);
      add(8'h94, 2, 2);
      add(8'h04, 1, 1);
      add(8'h08, 1, 2);
      add(8'h06, 1, 3);
      add(8'h96, 1, 2);
      add(8'h15, 2, 3);
      add(8'hA3, 1, 4);
      add(8'h84, 1, 11);
      add(8'hF4, 1, 1);
      add(8'hA4, 1, 11);
      add(8'hD4, 1, 1);
      add(8'hE4, 1, 1);
      run();
   endtask : t_arith
   task automatic t_logic();
      ent.delete();
      add(8'h00, 1, 1);
      add(8'h58, 1, 1);
      add(8'h53, 3, 3);
      add(8'h47, 1, 2);
      add(8'h42, 2, 3);
      add(8'h6F, 1, 1);
      add(8'h63, 3, 3);
      add(8'h13, 1, 1);
      add(8'h23, 1, 1);
      add(8'hC4, 1, 4);
      add(8'h55, 2, 2);
      add(8'h52, 2, 3);
      add(8'h44, 2, 2);
      add(8'h43, 3, 3);
      add(8'h65, 2, 2);
      add(8'h62, 2, 3);
      add(8'h33, 1, 1);
      add(8'h03, 1, 1);
      run();
   endtask : t_logic
   task automatic t_move();
      ent.delete();
      add(8'h00, 1, 1);
      add(8'hE7, 1, 2);
      add(8'hA8, 2, 3);
      add(8'h86, 2, 3);
      add(8'h75, 3, 3);
      add(8'hA7, 2, 3);
      add(8'h90, 3, 3);
      add(8'h93, 1, 7);
      add(8'h83, 1, 8);
      add(8'hE5, 2, 2);
      add(8'h74, 2, 2);
      add(8'hE8, 1, 1);
      add(8'hF8, 1, 2);
      add(8'h78, 2, 2);
      add(8'h88, 2, 2);
      add(8'hF5, 2, 2);
      add(8'h85, 3, 3);
      add(8'hF6, 1, 2);
      add(8'h76, 2, 2);
      run();
   endtask : t_move
   task automatic t_ext();
      ent.delete();
      muldiv_wide = 1'b1;
      add(8'h00, 1, 1);
      add(8'hE3, 1, 5);
      add(8'hE0, 1, 6);
      add(8'hF2, 1, 4);
      add(8'hF0, 1, 5);
      add(8'hC0, 2, 5);
      add(8'hD0, 2, 4);
      add(8'hCF, 1, 3);
      add(8'hC6, 1, 4);
      add(8'hD7, 1, 4);
      add(8'hA4, 1, 20);
      add(8'h84, 1, 20);
      add(8'hE2, 1, 5);
      add(8'hF3, 1, 4);
      add(8'hC5, 2, 4);
      add(8'hD6, 1, 4);
      run();
   endtask : t_ext
   // a refused operand byte stretches the instruction by one cycle
   task automatic t_stall();
      ent.delete();
      stall_addr = 16'h0002;
      add(8'h00, 1, 1);
      add(8'h85, 3, 3, 1);
      add(8'h28, 1, 1);
      run();
   endtask : t_stall
   task automatic results();
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results
   initial begin
      repeat (12) @(posedge clk);
      #1;
      t_arith();
      t_logic();
      t_move();
      t_ext();
      t_stall();
      results();
   end
   // watchdog well beyond the few hundred cycles that the scenarios need
   initial begin
      #20000;
      n_mismatch++;
      results();
   end
endmodule : pmd_decoder_tb
